// ===== logic/supply_monitor_params.svh
// Offsets, field positions, reset values and timing counts of the supply monitor.
`ifndef SUPPLY_MONITOR_PARAMS_SVH
`define SUPPLY_MONITOR_PARAMS_SVH
`define CLK_FREQ_MHZ 10
`define IDX_MODE_ZERO 8'h04
`define IDX_MODE_ONE 8'h05
`define IDX_STATUS_ONE 8'h31
`define IDX_DET_ENABLE 8'h32
`define IDX_MON1_CTRL 8'h36
`define IDX_MON2_CTRL 8'h37
`define IDX_MON0_CTRL 8'h38
`define IDX_COMP_SEL 8'h3a
`define BIT_SW_RESET 3
`define BIT_WDT_RESET_SEL 2
`define BIT_DET2_FLAG 3
`define BIT_DET0_EN 5
`define BIT_DET1_EN 6
`define BIT_DET2_EN 7
`define BIT_MON0_RST_EN 0
`define BIT_MON0_FILT_EN 1
`define BIT_MON0_MODE 6
`define OPT_BIT_DET0 5
`define STATUS_ONE_RESET 8'h08
`define DET_ENABLE_ON 8'h20
`define DET_ENABLE_OFF 8'h00
`define MON0_CTRL_ON 8'h43
`define MON0_CTRL_OFF 8'h00
`define MON_CTRL_RESET 8'h00
`define RELEASE_COUNT 32
`define STAB_TIME_US 100
`define STAB_CYCLES (`STAB_TIME_US * `CLK_FREQ_MHZ)
`define STAB_CNT_W 10
`define FILT_SHIFT_DET0 3'd2
`define FILT_SHIFT_DET12 3'd1
`endif

// ===== logic/supply_monitor_pkg.sv
// Types shared by the supply monitor reset control.
package supply_monitor_pkg;
    typedef enum logic [1:0] {S_RUN, S_HOLD, S_COUNT} rst_state_t;
    typedef struct packed {
        logic fall_en;
        logic rise_en;
        logic [1:0] div_sel;
        logic level_flag;
        logic rst_sel;
        logic filt_en;
        logic int_en;
    } mon_ctrl_t;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;
endpackage

// ===== logic/supply_monitor_reset_control.sv
// Supply monitor reset sequencer with three filtered detectors and an APB register file.
// What this block does
// - Detector-0 low supply asserts system reset.
// - Count 32 cycles after recovery, then release.
// - Any reset selects slow oscillator divided by eight.
// - Option bit enables detector-0 reset, hardware reset only.
// - Option bit set by programmer, never by CPU.
// - Detector-1 low supply with reset selected resets.
// - Detector-2 low supply with reset selected resets.
// - Watchdog underflow resets only when select bit set.
// - Writing one to software reset bit resets.
// - No reset clears RAM; interrupted writes undefined.
// - Detector 0 falls only; detectors 1, 2 both.
// - Detectors 1, 2 interrupt on rise, fall or both.
// - Detectors 1, 2 or comparators, one at a time.
// - Status register resets 08h, bit 3 read-only flag.
// - Readable detector-1 level flag.
// - Detector-2 flag forced one while disabled.
// - Enable and status survive system resets other than pin and detector-0 resets.
// - Enabled detector waits a stabilisation delay first.
`timescale 1ns/1ns
`include "supply_monitor_params.svh"
module supply_monitor_reset_control (
    input wire logic CLK_I, // Low-speed oscillator clock, 10 MHz.
    input wire logic RST_N_I, // Hardware pin reset, synchronous, active low.
    input wire logic [2:0] COMP_ABOVE_I, // Comparator outputs, high when supply at or above level.
    input wire logic [7:0] OPT_BYTE_I, // Option byte from flash.
    input wire logic WDT_UNDERFLOW_I, // Watchdog underflow pulse.
    input wire logic RAM_WRITE_I, // High while a RAM write is in progress.
    input wire logic PSEL_I, // APB select.
    input wire logic PENABLE_I, // APB enable.
    input wire logic PWRITE_I, // APB direction.
    input wire logic [11:0] PADDR_I, // APB byte address.
    input wire logic [31:0] PWDATA_I, // APB write data.
    output logic [31:0] PRDATA_O, // APB read data.
    output logic PREADY_O, // APB ready.
    output logic PSLVERR_O, // APB error on unmapped address.
    output logic SYS_RST_O, // System reset to pins, CPU and registers.
    output logic CPU_CLKSEL_O, // Pulse: CPU clock to slow oscillator divided by eight.
    output logic [1:0] DET_INT_O, // Interrupt pulses of detectors 1 and 2.
    output logic RAM_UNDEF_O // Pulse: RAM write cut by a supply reset.
);
    supply_monitor_pkg::apb_req_t req;
    supply_monitor_pkg::rst_state_t state_reg;
    supply_monitor_pkg::mon_ctrl_t mon_ctrl [1:2];
    logic [4:0] cnt_reg;
    logic sys_rst_reg, clksel_reg, ram_undef_reg, hw_init_reg, det0_opt_reg;
    logic [7:0] pm1_reg, enable_reg, mon0_reg, mon1_reg, mon2_reg, comp_reg;
    logic [7:0] status_one;
    logic [31:0] rdata_reg;
    logic [4:0] div_cnt_reg;
    logic [2:0] det_en, det_filt_en, det_active, det_filt, det_fall, det_rise;
    logic [1:0] det_div [3];
    logic [2:0] det_shift [3];
    logic [1:0] det_int;
    logic wr_en, rd_setup, hit, sw_req, det0_hold, det1_hold, det2_hold, hold_src, pulse_src;
    logic [7:0] rd_mux;

    function automatic logic sample_tick(input logic [4:0] cnt, input logic [2:0] shift);
        sample_tick = ((cnt & ((5'd1 << shift) - 5'd1)) == 5'd0);
    endfunction

    function automatic logic idx_hit(input logic [11:0] addr, input logic [7:0] idx);
        idx_hit = (addr == {2'b00, idx, 2'b00});
    endfunction

    assign req = '{psel: PSEL_I, penable: PENABLE_I, pwrite: PWRITE_I,
                   paddr: PADDR_I, pwdata: PWDATA_I};
    assign hit = idx_hit(req.paddr, `IDX_MODE_ZERO) || idx_hit(req.paddr, `IDX_MODE_ONE)
        || idx_hit(req.paddr, `IDX_STATUS_ONE) || idx_hit(req.paddr, `IDX_DET_ENABLE)
        || idx_hit(req.paddr, `IDX_MON1_CTRL) || idx_hit(req.paddr, `IDX_MON2_CTRL)
        || idx_hit(req.paddr, `IDX_MON0_CTRL) || idx_hit(req.paddr, `IDX_COMP_SEL);
    assign wr_en = req.psel && req.penable && req.pwrite && hit;
    assign rd_setup = req.psel && !req.penable && !req.pwrite;
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = req.psel && req.penable && !hit;
    assign PRDATA_O = rdata_reg;
    assign SYS_RST_O = sys_rst_reg;
    assign CPU_CLKSEL_O = clksel_reg;
    assign RAM_UNDEF_O = ram_undef_reg;
    assign mon_ctrl[1] = mon1_reg;
    assign mon_ctrl[2] = mon2_reg;

    // Per-detector configuration gathered from the control registers.
    always_comb begin
        det_en = {enable_reg[`BIT_DET2_EN], enable_reg[`BIT_DET1_EN], enable_reg[`BIT_DET0_EN]};
        det_filt_en = {mon_ctrl[2].filt_en, mon_ctrl[1].filt_en, mon0_reg[`BIT_MON0_FILT_EN]};
        det_div[0] = mon0_reg[5:4];
        det_div[1] = mon_ctrl[1].div_sel;
        det_div[2] = mon_ctrl[2].div_sel;
        det_shift[0] = {1'b0, det_div[0]} + `FILT_SHIFT_DET0;
        det_shift[1] = {1'b0, det_div[1]} + `FILT_SHIFT_DET12;
        det_shift[2] = {1'b0, det_div[2]} + `FILT_SHIFT_DET12;
    end

    // Free-running divider that paces every filter sample.
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            div_cnt_reg <= 5'h00;
        end else begin
            div_cnt_reg <= div_cnt_reg + 5'h01;
        end
    end

    for (genvar i = 0; i < 3; i++) begin : g_det
        logic [2:0] sync_reg;
        logic lvl_reg, sample_reg, filt_reg, prev_reg;
        logic [`STAB_CNT_W-1:0] stab_reg;
        logic active;
        assign active = det_en[i] && (stab_reg == `STAB_CNT_W'(`STAB_CYCLES));
        assign det_active[i] = active;
        assign det_filt[i] = filt_reg;
        assign det_fall[i] = active && prev_reg && !filt_reg;
        // Detector 0 only acts on the level being low, never on a rising crossing.
        assign det_rise[i] = (i != 0) && active && !prev_reg && filt_reg;

        always_ff @(posedge CLK_I) begin
            if (!RST_N_I) begin
                sync_reg <= 3'h7;
                lvl_reg <= 1'b1;
            end else begin
                sync_reg <= {sync_reg[1:0], COMP_ABOVE_I[i]};
                if (sync_reg[1] == sync_reg[2]) begin
                    lvl_reg <= sync_reg[2];
                end
            end
        end

        // A freshly enabled circuit is ignored until the settling time has passed.
        always_ff @(posedge CLK_I) begin
            if (!RST_N_I || !det_en[i]) begin
                stab_reg <= '0;
            end else if (!active) begin
                stab_reg <= stab_reg + `STAB_CNT_W'(1);
            end
        end

        always_ff @(posedge CLK_I) begin
            if (!RST_N_I || !active) begin
                sample_reg <= 1'b1;
                filt_reg <= 1'b1;
                prev_reg <= 1'b1;
            end else begin
                prev_reg <= filt_reg;
                if (!det_filt_en[i]) begin
                    filt_reg <= lvl_reg;
                end else if (sample_tick(div_cnt_reg, det_shift[i])) begin
                    sample_reg <= lvl_reg;
                    if (sample_reg == lvl_reg) begin
                        filt_reg <= lvl_reg;
                    end
                end
            end
        end

        if (i != 0) begin : g_int
            assign det_int[i-1] = mon_ctrl[i].int_en && !comp_reg[i-1]
                && ((det_fall[i] && mon_ctrl[i].fall_en)
                || (det_rise[i] && mon_ctrl[i].rise_en));
        end
    end

    assign DET_INT_O = det_int;
    assign det0_hold = det_active[0] && !det_filt[0] && mon0_reg[`BIT_MON0_RST_EN]
        && mon0_reg[`BIT_MON0_MODE];
    assign det1_hold = det_active[1] && !det_filt[1] && mon_ctrl[1].rst_sel
        && !comp_reg[0];
    assign det2_hold = det_active[2] && !det_filt[2] && mon_ctrl[2].rst_sel
        && !comp_reg[1];
    assign hold_src = det0_hold || det1_hold || det2_hold;
    assign sw_req = wr_en && idx_hit(req.paddr, `IDX_MODE_ZERO)
        && req.pwdata[`BIT_SW_RESET];
    assign pulse_src = sw_req || (WDT_UNDERFLOW_I && pm1_reg[`BIT_WDT_RESET_SEL]);

    // Reset sequencer: hold while a supply is low, then count out the release delay.
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            state_reg <= supply_monitor_pkg::S_COUNT;
            cnt_reg <= 5'h00;
            sys_rst_reg <= 1'b1;
        end else begin
            unique case (state_reg)
                supply_monitor_pkg::S_RUN: begin
                    if (hold_src) begin
                        state_reg <= supply_monitor_pkg::S_HOLD;
                        sys_rst_reg <= 1'b1;
                    end else if (pulse_src) begin
                        state_reg <= supply_monitor_pkg::S_COUNT;
                        cnt_reg <= 5'h00;
                        sys_rst_reg <= 1'b1;
                    end
                end
                supply_monitor_pkg::S_HOLD: begin
                    if (!hold_src) begin
                        state_reg <= supply_monitor_pkg::S_COUNT;
                        cnt_reg <= 5'h00;
                    end
                end
                supply_monitor_pkg::S_COUNT: begin
                    if (hold_src) begin
                        state_reg <= supply_monitor_pkg::S_HOLD;
                    end else if (cnt_reg == 5'(`RELEASE_COUNT - 1)) begin
                        state_reg <= supply_monitor_pkg::S_RUN;
                        sys_rst_reg <= 1'b0;
                    end else begin
                        cnt_reg <= cnt_reg + 5'h01;
                    end
                end
            endcase
        end
    end

    // Every release of the system reset restarts the CPU on the slow clock divided by eight.
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            clksel_reg <= 1'b0;
        end else begin
            clksel_reg <= state_reg == supply_monitor_pkg::S_COUNT && !hold_src
                && cnt_reg == 5'(`RELEASE_COUNT - 1);
        end
    end

    // RAM has no reset path; a write cut by a supply reset is only reported.
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            ram_undef_reg <= 1'b0;
        end else begin
            ram_undef_reg <= !sys_rst_reg && hold_src && RAM_WRITE_I;
        end
    end

    // The option bit is taken from flash only in the first cycle after a pin reset.
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            hw_init_reg <= 1'b1;
            det0_opt_reg <= 1'b1;
        end else begin
            hw_init_reg <= 1'b0;
            if (hw_init_reg) begin
                det0_opt_reg <= OPT_BYTE_I[`OPT_BIT_DET0];
            end
        end
    end

    // Enable and monitor controls survive every reset but pin and detector-0 resets.
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            enable_reg <= `DET_ENABLE_OFF;
            mon0_reg <= `MON0_CTRL_OFF;
            mon1_reg <= `MON_CTRL_RESET;
            mon2_reg <= `MON_CTRL_RESET;
            comp_reg <= 8'h00;
        end else if (hw_init_reg || det0_hold) begin
            enable_reg <= (det0_hold || !OPT_BYTE_I[`OPT_BIT_DET0]) ? `DET_ENABLE_ON
                : `DET_ENABLE_OFF;
            mon0_reg <= (det0_hold || !OPT_BYTE_I[`OPT_BIT_DET0]) ? `MON0_CTRL_ON
                : `MON0_CTRL_OFF;
            mon1_reg <= `MON_CTRL_RESET;
            mon2_reg <= `MON_CTRL_RESET;
            comp_reg <= 8'h00;
        end else if (wr_en) begin
            if (idx_hit(req.paddr, `IDX_DET_ENABLE)) begin
                enable_reg <= req.pwdata[7:0] & 8'he1;
            end
            if (idx_hit(req.paddr, `IDX_MON0_CTRL)) begin
                mon0_reg <= req.pwdata[7:0] & 8'h73;
            end
            if (idx_hit(req.paddr, `IDX_MON1_CTRL)) begin
                mon1_reg <= req.pwdata[7:0] & 8'hf7;
            end
            if (idx_hit(req.paddr, `IDX_MON2_CTRL)) begin
                mon2_reg <= req.pwdata[7:0] & 8'hf7;
            end
            if (idx_hit(req.paddr, `IDX_COMP_SEL)) begin
                comp_reg <= req.pwdata[7:0] & 8'h03;
            end
        end
    end

    // Processor mode bits are cleared by every system reset.
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I || sys_rst_reg) begin
            pm1_reg <= 8'h00;
        end else if (wr_en && idx_hit(req.paddr, `IDX_MODE_ONE)) begin
            pm1_reg <= req.pwdata[7:0] & 8'h04;
        end
    end

    always_comb begin
        status_one = `STATUS_ONE_RESET;
        status_one[`BIT_DET2_FLAG] = !det_en[2] || det_filt[2];
    end

    always_comb begin
        rd_mux = 8'h00;
        if (idx_hit(req.paddr, `IDX_MODE_ONE)) begin
            rd_mux = pm1_reg;
        end else if (idx_hit(req.paddr, `IDX_STATUS_ONE)) begin
            rd_mux = status_one;
        end else if (idx_hit(req.paddr, `IDX_DET_ENABLE)) begin
            rd_mux = enable_reg;
        end else if (idx_hit(req.paddr, `IDX_MON0_CTRL)) begin
            rd_mux = mon0_reg;
        end else if (idx_hit(req.paddr, `IDX_MON1_CTRL)) begin
            rd_mux = mon1_reg | {4'h0, !det_en[1] || det_filt[1], 3'h0};
        end else if (idx_hit(req.paddr, `IDX_MON2_CTRL)) begin
            rd_mux = mon2_reg | {4'h0, status_one[`BIT_DET2_FLAG], 3'h0};
        end else if (idx_hit(req.paddr, `IDX_COMP_SEL)) begin
            rd_mux = comp_reg | {2'h0, det_filt[2:1], 4'h0};
        end
    end

    // Read data is captured in the setup cycle and stands through the access cycle.
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            rdata_reg <= 32'h0000_0000;
        end else if (rd_setup) begin
            rdata_reg <= {24'h00_0000, rd_mux};
        end
    end

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);

    a_det0_reset_now: assert property (
        state_reg == supply_monitor_pkg::S_RUN && det0_hold |=> SYS_RST_O)
        else $error("Detector 0 low did not raise system reset.");
    a_release_start: assert property (
        state_reg == supply_monitor_pkg::S_HOLD && !hold_src |=> cnt_reg == 5'h00 && SYS_RST_O)
        else $error("Release count did not start at zero.");
    a_release_end: assert property (
        state_reg == supply_monitor_pkg::S_COUNT && cnt_reg == 5'd31 && !hold_src
        |=> !SYS_RST_O)
        else $error("Reset not released after 32 cycles.");
    a_clock_select: assert property (
        $fell(SYS_RST_O) |-> CPU_CLKSEL_O)
        else $error("Clock select pulse missing at reset release.");
    a_option_capture: assert property (
        hw_init_reg |=> det0_opt_reg == $past(OPT_BYTE_I[5]))
        else $error("Option bit not captured after pin reset.");
    a_wdt_gate: assert property (
        state_reg == supply_monitor_pkg::S_RUN && !hold_src && !sw_req && WDT_UNDERFLOW_I
        |=> SYS_RST_O == $past(pm1_reg[2]))
        else $error("Watchdog reset ignored its select bit.");
    a_sw_reset: assert property (
        state_reg == supply_monitor_pkg::S_RUN && sw_req |=> SYS_RST_O ##1 SYS_RST_O)
        else $error("Software reset request lost.");
    a_status_layout: assert property (
        rd_setup && idx_hit(req.paddr, `IDX_STATUS_ONE) |=> (PRDATA_O & 32'hffff_fff7) == 32'h0)
        else $error("Reserved status bits not zero.");
    a_det2_forced: assert property (
        !det_en[2] |-> status_one[3])
        else $error("Detector 2 flag not forced high while disabled.");
    a_int_cause: assert property (
        DET_INT_O[0] |-> (det_fall[1] || det_rise[1]) && !comp_reg[0])
        else $error("Detector 1 interrupt without a crossing.");
    a_stab_wait: assert property (
        det_en[1] && !$past(det_en[1]) |-> !det_active[1] [*8])
        else $error("Detector 1 active before settling time.");

    c_supply_release: cover property (
        state_reg == supply_monitor_pkg::S_HOLD ##1 state_reg == supply_monitor_pkg::S_COUNT);
    c_det1_int: cover property (DET_INT_O[0]);
    c_wdt_reset: cover property (WDT_UNDERFLOW_I && pm1_reg[2] ##1 SYS_RST_O);
    c_sw_reset: cover property (sw_req ##1 SYS_RST_O);
endmodule

// ===== testbench/supply_monitor_reset_control_tb.sv
// Self-checking bench of the supply monitor reset control against a register and reset model.
`timescale 1ns/1ns
`include "supply_monitor_params.svh"
module supply_monitor_reset_control_tb;
    localparam logic [11:0] A_M0 = 12'(`IDX_MODE_ZERO) << 2;
    localparam logic [11:0] A_M1 = 12'(`IDX_MODE_ONE) << 2;
    localparam logic [11:0] A_ST = 12'(`IDX_STATUS_ONE) << 2;
    localparam logic [11:0] A_EN = 12'(`IDX_DET_ENABLE) << 2;
    localparam logic [11:0] A_W1 = 12'(`IDX_MON1_CTRL) << 2;
    localparam logic [11:0] A_W2 = 12'(`IDX_MON2_CTRL) << 2;
    localparam logic [11:0] A_W0 = 12'(`IDX_MON0_CTRL) << 2;
    localparam logic [11:0] A_CS = 12'(`IDX_COMP_SEL) << 2;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] lvl = 3'h7;
    logic wdt_req = 1'b0;
    logic ram_wr = 1'b0;
    logic [7:0] opt = 8'hdf;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [2:0] comp;
    logic wdt, pready, pslverr, sys_rst, clksel, ram_undef;
    logic [31:0] prdata;
    logic [1:0] det_int;
    logic [31:0] seed = 32'hd8f32f11;
    logic [31:0] rv;
    logic [11:0] ua, wa;
    logic [7:0] mdl [logic [11:0]];
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    int n;

    supply_partner far (.clk_i(clk), .level_i(lvl), .wdt_req_i(wdt_req), .comp_o(comp),
        .wdt_o(wdt));
    // The option byte keeps detector-0 reset enabled.
    supply_monitor_reset_control uut (.CLK_I(clk), .RST_N_I(rst_n), .COMP_ABOVE_I(comp),
        .OPT_BYTE_I(opt), .WDT_UNDERFLOW_I(wdt), .RAM_WRITE_I(ram_wr), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .SYS_RST_O(sys_rst),
        .CPU_CLKSEL_O(clksel), .DET_INT_O(det_int), .RAM_UNDEF_O(ram_undef));

    initial forever #50 clk = ~clk;

    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function logic mapped(input logic [11:0] a);
        return a inside {A_M0, A_M1, A_ST, A_EN, A_W1, A_W2, A_W0, A_CS};
    endfunction

    function logic [7:0] wmask(input logic [11:0] a);
        case (a)
            A_M1: return 8'h04;
            A_EN: return 8'he1;
            A_W1, A_W2: return 8'hf7;
            A_W0: return 8'h73;
            A_CS: return 8'h03;
            default: return 8'h00;
        endcase
    endfunction

    // Level flags are live: forced high while the detector is off.
    function logic [7:0] exp_rd(input logic [11:0] a);
        logic [7:0] v;
        v = mdl.exists(a) ? mdl[a] : 8'h00;
        if (a == A_ST || a == A_W2) v[3] = ~mdl[A_EN][7] | lvl[2];
        if (a == A_W1) v[3] = ~mdl[A_EN][6] | lvl[1];
        if (a == A_CS) v[5:4] = {~mdl[A_EN][7] | lvl[2], ~mdl[A_EN][6] | lvl[1]};
        return v;
    endfunction

    task mdl_reset(input logic full);
        if (full) begin
            mdl.delete();
            mdl[A_EN] = `DET_ENABLE_ON;
            mdl[A_W0] = `MON0_CTRL_ON;
        end
        mdl[A_M1] = 8'h00;
    endtask

    task xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
        int k;
        logic [31:0] u;
        logic [7:0] old;
        u = xs();
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {u[31:8], d};
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        chk(pready, 1'b1);
        chk(pslverr, !mapped(a));
        if (!w) chk(prdata, {24'h0, exp_rd(a)});
        psel <= 1'b0;
        penable <= 1'b0;
        old = mdl.exists(a) ? mdl[a] : 8'h00;
        if (w && mapped(a)) mdl[a] = (old & ~wmask(a)) | (d & wmask(a));
    endtask

    function logic pick(input int s);
        case (s)
            0: return sys_rst;
            1: return det_int[0];
            2: return det_int[1];
            default: return ram_undef;
        endcase
    endfunction

    task wait_for(input int s, input logic v, input int lim, output int k);
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pick(s) !== v && k < lim);
    endtask

    // Counts the sampled cycles of system reset, then checks the clock-select pulse.
    task measure(output int k);
        int j;
        wait_for(0, 1'b1, 100, j);
        k = 0;
        while (sys_rst === 1'b1 && k < 2000) begin
            k++;
            @(posedge clk);
        end
        chk(clksel, 1'b1);
    endtask

    task done(input string s);
        $display("test %s finished", s);
    endtask

    task stop_test();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 12000) begin
            error_cnt++;
            stop_test();
        end
    end

    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        measure(n);
        chk(n, `RELEASE_COUNT);
        mdl_reset(1'b1);
        xfer(1'b0, A_ST, 8'h00);
        xfer(1'b0, A_EN, 8'h00);
        xfer(1'b0, A_W0, 8'h00);
        rv = xs();
        xfer(1'b1, A_ST, rv[7:0]);
        xfer(1'b0, A_ST, 8'h00);
        ua = {1'b1, rv[10:2], 2'b00};
        xfer(1'b1, ua, rv[15:8]);
        xfer(1'b0, ua, 8'h00);
        xfer(1'b1, A_EN, {7'h70, rv[0]});
        xfer(1'b0, A_EN, 8'h00);
        done("registers");
        xfer(1'b1, A_M0, 8'h08);
        measure(n);
        chk(n, `RELEASE_COUNT);
        mdl_reset(1'b0);
        xfer(1'b0, A_M0, 8'h00);
        xfer(1'b0, A_EN, 8'h00);
        for (int s = 0; s < 2; s++) begin
            xfer(1'b1, A_M1, s ? 8'h04 : 8'h00);
            xfer(1'b0, A_M1, 8'h00);
            wdt_req <= 1'b1;
            if (s == 0) wait_for(0, 1'b1, 40, n);
            else measure(n);
            chk(n, s ? `RELEASE_COUNT : 40);
            wdt_req <= 1'b0;
            mdl_reset(1'b0);
        end
        xfer(1'b0, A_M1, 8'h00);
        done("software and watchdog");
        repeat (1100) @(posedge clk);
        for (int d = 1; d < 3; d++) begin
            wa = (d == 1) ? A_W1 : A_W2;
            xfer(1'b1, wa, 8'hc1);
            for (int p = 0; p < 4; p++) begin
                lvl[d] <= p[0];
                wait_for(d, 1'b1, 60, n);
                chk(n < 60, p != 3);
                xfer(1'b0, wa, 8'h00);
                xfer(1'b0, A_ST, 8'h00);
                if (p == 1) xfer(1'b1, wa, 8'h81);
            end
            // In comparator mode a falling crossing must raise no interrupt.
            xfer(1'b1, A_CS, 8'(d));
            lvl[d] <= 1'b0;
            wait_for(d, 1'b1, 60, n);
            chk(n < 60, 1'b0);
            xfer(1'b0, A_CS, 8'h00);
            lvl[d] <= 1'b1;
            repeat (8) @(posedge clk);
            xfer(1'b1, A_CS, 8'h00);
            xfer(1'b1, wa, 8'h04);
            lvl[d] <= 1'b0;
            wait_for(0, 1'b1, 100, n);
            chk(n < 100, 1'b1);
            repeat (40) @(posedge clk);
            chk(sys_rst, 1'b1);
            lvl[d] <= 1'b1;
            measure(n);
            chk(n > `RELEASE_COUNT, 1'b1);
            mdl_reset(1'b0);
            xfer(1'b0, wa, 8'h00);
            xfer(1'b0, A_EN, 8'h00);
        end
        done("detectors 1 and 2");
        ram_wr <= 1'b1;
        lvl[0] <= 1'b0;
        wait_for(3, 1'b1, 100, n);
        chk(n < 100, 1'b1);
        wait_for(0, 1'b1, 100, n);
        ram_wr <= 1'b0;
        repeat (40) @(posedge clk);
        chk(sys_rst, 1'b1);
        lvl[0] <= 1'b1;
        measure(n);
        chk(n > `RELEASE_COUNT, 1'b1);
        mdl_reset(1'b1);
        xfer(1'b0, A_EN, 8'h00);
        xfer(1'b0, A_W0, 8'h00);
        xfer(1'b0, A_W1, 8'h00);
        done("detector 0");
        // A pin reset with the option bit set leaves detector 0 switched off.
        opt <= 8'hff;
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        measure(n);
        chk(n, `RELEASE_COUNT);
        mdl_reset(1'b1);
        mdl[A_EN] = `DET_ENABLE_OFF;
        mdl[A_W0] = `MON0_CTRL_OFF;
        xfer(1'b0, A_EN, 8'h00);
        xfer(1'b0, A_W0, 8'h00);
        xfer(1'b0, A_ST, 8'h00);
        done("pin reset with option set");
        stop_test();
    end
endmodule

// ===== testbench/supply_partner.sv
// Far-side model: supply comparators and a watchdog that issues underflow pulses.
`timescale 1ns/1ns
module supply_partner (
    input wire logic clk_i, // Slow oscillator clock.
    input wire logic [2:0] level_i, // Supply state per detector, 1 = at or above level.
    input wire logic wdt_req_i, // A rising edge asks for one underflow.
    output logic [2:0] comp_o, // Comparator outputs.
    output logic wdt_o // Underflow pulse, one cycle.
);
    logic wdt_d = 1'b0;
    initial comp_o = 3'h7;
    initial wdt_o = 1'b0;
    // Comparators settle off the clock grid and report both crossings.
    always @(level_i) comp_o <= #37 level_i;
    always @(posedge clk_i) begin
        wdt_d <= wdt_req_i;
        wdt_o <= wdt_req_i & ~wdt_d;
    end
endmodule
